//--- rtl/pdrst_pkg.sv
package pdrst_pkg;

   // link symbols carried between port end and plug end
   typedef enum logic [2:0] {
      pdrst_sym_idle_type,
      pdrst_sym_sop_type,
      pdrst_sym_sop_p_type,
      pdrst_sym_sop_pp_type,
      pdrst_sym_hard_reset_type,
      pdrst_sym_cable_reset_type,
      pdrst_sym_soft_reset_type
   } pdrst_sym_type;

   // connection phase as seen by the port
   typedef enum logic [1:0] {
      pdrst_ph_none_type,
      pdrst_ph_establishing_type,
      pdrst_ph_contract_setup_type,
      pdrst_ph_explicit_type
   } pdrst_phase_type;

   localparam int unsigned PDRST_CLK_MHZ            = 100;
   localparam int unsigned PDRST_NO_RESP_MS         = 5;
   localparam int unsigned PDRST_NO_RESP_CYC        = PDRST_NO_RESP_MS * PDRST_CLK_MHZ * 1000;
   localparam int unsigned PDRST_CNT_W              = 32;
   localparam logic [1:0]  PDRST_HARD_RETRY_MAX     = 2'h2;
   localparam logic [1:0]  PDRST_RETRY_RST          = 2'h0;
   localparam logic [31:0] PDRST_TIMER_RST          = 32'h0;
   localparam logic [7:0]  PDRST_PLUG_DATA_RST      = 8'h0;

endpackage

//--- rtl/pdrst_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pdrst_link_if;
   import pdrst_pkg::*;
   // port to plug: one symbol per cycle with payload byte
   pdrst_sym_type  port_sym;
   logic [7:0]     port_data;
   // plug to port: answers to plug exchanges
   pdrst_sym_type  plug_sym;
   logic [7:0]     plug_data;

   modport port_end (output port_sym, output port_data, input plug_sym, input plug_data);
   modport plug_end (input port_sym, input port_data, output plug_sym, output plug_data);
endinterface
`default_nettype wire

//--- rtl/pdrst_port.sv
`timescale 1ns/1ns
`default_nettype none
module pdrst_port #(
   parameter int unsigned NO_RESP_CYC = pdrst_pkg::PDRST_NO_RESP_CYC
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_n_i,
   input  wire pdrst_pkg::pdrst_phase_type phase_i,
   input  wire logic                     acting_source_i,
   input  wire logic                     drp_source_default_i,
   input  wire logic                     safe_zero_default_i,
   input  wire logic                     protocol_error_i,
   input  wire logic                     serious_error_i,
   input  wire logic                     rx_soft_reset_i,
   input  wire logic                     rx_hard_reset_i,
   input  wire logic                     partner_response_i,
   input  wire logic                     rx_sop_i,
   input  wire logic                     sop_req_i,
   input  wire logic                     sop_busy_i,
   input  wire logic                     plug_req_i,
   input  wire logic                     plug_dbl_i,
   input  wire logic [7:0]               plug_req_data_i,
   input  wire logic                     cable_reset_req_i,
   input  wire logic                     mode_enter_i,
   pdrst_link_if.port_end                link,
   output logic                          tx_soft_reset_o,
   output logic                          tx_hard_reset_o,
   output logic                          supply_default_o,
   output logic                          role_source_o,
   output logic                          safe_zero_sel_o,
   output logic                          safe_five_sel_o,
   output logic                          modal_o,
   output logic                          wait_for_source_offer_state_o,
   output logic                          connection_ended_o,
   output logic                          plug_busy_o,
   output logic                          plug_done_o,
   output logic [7:0]                    plug_rx_data_o,
   output logic                          sop_grant_o,
   output logic [1:0]                    retry_count_o
);
   import pdrst_pkg::*;

   typedef struct packed {
      logic [PDRST_CNT_W-1:0] timer;
      logic                   timing;
      logic [1:0]             retry;
      logic                   soft_tx;
      logic                   hard_tx;
      logic                   supply_def;
      logic                   role_src;
      logic                   sel0;
      logic                   sel5;
      logic                   modal;
      logic                   wait_offer;
      logic                   ended;
      logic                   plug_busy;
      logic                   plug_done;
      logic [7:0]             plug_rx;
      logic                   grant;
      pdrst_sym_type          sym;
      logic [7:0]             data;
   } pdrst_port_st_type;

   pdrst_port_st_type st_q;
   pdrst_port_st_type st_d;
   logic              plug_allowed;
   logic              hard_now;

   // which phase lets the port start a plug exchange
   always_comb
   begin
      case (phase_i)
         pdrst_ph_none_type:           plug_allowed = acting_source_i && !plug_dbl_i;
         pdrst_ph_establishing_type:   plug_allowed = 1'b0;
         pdrst_ph_contract_setup_type: plug_allowed = acting_source_i && !plug_dbl_i;
         pdrst_ph_explicit_type:       plug_allowed = !sop_busy_i && !sop_req_i;
         default:                      plug_allowed = 1'b0;
      endcase
   end

   // hard_now is only a local serious error; timeout retries enter through st_d.hard_tx, since reading the next state here would close a loop
   assign hard_now = serious_error_i;

   // next state of the whole port
   always_comb
   begin
      st_d          = st_q;
      st_d.soft_tx  = 1'b0;
      st_d.hard_tx  = 1'b0;
      st_d.plug_done = 1'b0;
      st_d.sym      = pdrst_sym_idle_type;
      st_d.data     = PDRST_PLUG_DATA_RST;
      st_d.grant    = sop_req_i;
      if (mode_enter_i)
         st_d.modal = 1'b1;
      if (cable_reset_req_i && !sop_busy_i)
         st_d.sym = pdrst_sym_cable_reset_type;
      // plug exchange start and answer; silence is never treated as failure
      if (!st_q.plug_busy && plug_req_i && plug_allowed && !cable_reset_req_i)
      begin
         st_d.plug_busy = 1'b1;
         st_d.sym       = plug_dbl_i ? pdrst_sym_sop_pp_type : pdrst_sym_sop_p_type;
         st_d.data      = plug_req_data_i;
      end
      if (st_q.plug_busy && (link.plug_sym == pdrst_sym_sop_p_type || link.plug_sym == pdrst_sym_sop_pp_type))
      begin
         st_d.plug_busy = 1'b0;
         st_d.plug_done = 1'b1;
         st_d.plug_rx   = link.plug_data;
      end
      // partner traffic or an SOP request ends the plug exchange, no retry
      if (rx_sop_i || sop_req_i || phase_i == pdrst_ph_establishing_type)
         st_d.plug_busy = 1'b0;
      // no-response timer after a hard reset
      if (st_q.timing)
         st_d.timer = st_q.timer + 32'h1;
      if (partner_response_i)
      begin
         st_d.timing     = 1'b0;
         st_d.retry      = PDRST_RETRY_RST;
         st_d.ended      = 1'b0;
         st_d.wait_offer = 1'b0;
         st_d.supply_def = 1'b0;
      end
      else if (st_q.timing && st_q.timer >= NO_RESP_CYC - 1)
      begin
         st_d.timing = 1'b0;
         if (st_q.retry < PDRST_HARD_RETRY_MAX)
         begin
            st_d.retry   = st_q.retry + 2'h1;
            st_d.hard_tx = 1'b1;
            st_d.timer   = PDRST_TIMER_RST;
            st_d.timing  = 1'b1;
         end
         else
         begin
            st_d.ended      = 1'b1;
            st_d.wait_offer = 1'b1;
         end
      end
      // soft reset keeps supply, role and modes; it follows the timer so a running count cannot outlive it
      if (protocol_error_i)
      begin
         st_d.soft_tx = 1'b1;
         st_d.sym     = pdrst_sym_soft_reset_type;
      end
      if (protocol_error_i || rx_soft_reset_i)
      begin
         st_d.timer     = PDRST_TIMER_RST;
         st_d.timing    = 1'b0;
         st_d.retry     = PDRST_RETRY_RST;
         st_d.plug_busy = 1'b0;
      end
      // hard reset sent or received clears protocol state and restores supply default; role and safe selection only when drp_source_default_i is set
      if (hard_now || rx_hard_reset_i || st_d.hard_tx)
      begin
         st_d.hard_tx    = !rx_hard_reset_i;
         st_d.sym        = rx_hard_reset_i ? pdrst_sym_idle_type : pdrst_sym_hard_reset_type;
         st_d.timer      = PDRST_TIMER_RST;
         st_d.timing     = !rx_hard_reset_i;
         st_d.plug_busy  = 1'b0;
         st_d.supply_def = 1'b1;
         st_d.modal      = 1'b0;
         if (hard_now)
            st_d.retry = PDRST_RETRY_RST;
         if (drp_source_default_i)
         begin
            st_d.role_src = 1'b1;
            st_d.sel0     = safe_zero_default_i;
            st_d.sel5     = !safe_zero_default_i;
         end
      end
   end

   // single state register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q      <= '0;
         st_q.sym  <= pdrst_sym_idle_type;
      end
      else
         st_q <= st_d;
   end

   assign link.port_sym                 = st_q.sym;
   assign link.port_data                = st_q.data;
   assign tx_soft_reset_o               = st_q.soft_tx;
   assign tx_hard_reset_o               = st_q.hard_tx;
   assign supply_default_o              = st_q.supply_def;
   assign role_source_o                 = st_q.role_src;
   assign safe_zero_sel_o               = st_q.sel0;
   assign safe_five_sel_o               = st_q.sel5;
   assign modal_o                       = st_q.modal;
   assign wait_for_source_offer_state_o = st_q.wait_offer;
   assign connection_ended_o            = st_q.ended;
   assign plug_busy_o                   = st_q.plug_busy;
   assign plug_done_o                   = st_q.plug_done;
   assign plug_rx_data_o                = st_q.plug_rx;
   assign sop_grant_o                   = st_q.grant;
   assign retry_count_o                 = st_q.retry;
endmodule
`default_nettype wire

//--- rtl/pdrst_plug.sv
`timescale 1ns/1ns
`default_nettype none
module pdrst_plug (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   pdrst_link_if.plug_end  link,
   input  wire logic [7:0] answer_data_i,
   input  wire logic       answer_en_i,
   output logic            self_reset_o,
   output logic [7:0]      last_req_o
);
   import pdrst_pkg::*;

   typedef struct packed {
      pdrst_sym_type sym;
      logic [7:0]    data;
      logic          self_rst;
      logic [7:0]    last;
   } pdrst_plug_st_type;

   pdrst_plug_st_type st_q;
   pdrst_plug_st_type st_d;

   // answer plug packets; reset fully on hard reset or cable reset (soft reset is ignored), never send hard reset
   always_comb
   begin
      st_d          = st_q;
      st_d.sym      = pdrst_sym_idle_type;
      st_d.data     = PDRST_PLUG_DATA_RST;
      st_d.self_rst = 1'b0;
      if (link.port_sym == pdrst_sym_hard_reset_type || link.port_sym == pdrst_sym_cable_reset_type)
      begin
         st_d          = '0;
         st_d.sym      = pdrst_sym_idle_type;
         st_d.self_rst = 1'b1;
      end
      else if ((link.port_sym == pdrst_sym_sop_p_type || link.port_sym == pdrst_sym_sop_pp_type) && answer_en_i)
      begin
         st_d.sym  = link.port_sym;  // no retry if the port has moved on
         st_d.data = answer_data_i;
         st_d.last = link.port_data;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q     <= '0;
         st_q.sym <= pdrst_sym_idle_type;
      end
      else
         st_q <= st_d;
   end

   assign link.plug_sym  = st_q.sym;
   assign link.plug_data = st_q.data;
   assign self_reset_o   = st_q.self_rst;
   assign last_req_o     = st_q.last;
endmodule
`default_nettype wire

//--- dv/pdrst_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pdrst_monitor (
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire pdrst_pkg::pdrst_sym_type port_sym,
   input  wire logic [7:0]              port_data,
   input  wire pdrst_pkg::pdrst_sym_type plug_sym,
   input  wire logic [7:0]              plug_data
);
   import pdrst_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // a plug that is resetting itself must stay silent for two cycles
   sequence plug_quiet;
      plug_sym == pdrst_sym_idle_type [*2];
   endsequence
   sequence hard_sent;
      port_sym == pdrst_sym_hard_reset_type;
   endsequence

   a_plug_no_hard: assert property (plug_sym != pdrst_sym_hard_reset_type)
      else $error("plug end sent hard reset");
   a_plug_legal_sym: assert property (plug_sym inside {pdrst_sym_idle_type, pdrst_sym_sop_p_type,
      pdrst_sym_sop_pp_type}) else $error("plug end sent a port symbol");
   a_plug_p_answer: assert property (plug_sym == pdrst_sym_sop_p_type |->
      $past(port_sym) == pdrst_sym_sop_p_type) else $error("plug answered without request");
   a_plug_pp_answer: assert property (plug_sym == pdrst_sym_sop_pp_type |->
      $past(port_sym) == pdrst_sym_sop_pp_type) else $error("plug double answer unrequested");
   a_hard_quiet_plug: assert property (hard_sent |=> plug_quiet)
      else $error("plug spoke after hard reset");
   a_cable_quiet_plug: assert property (port_sym == pdrst_sym_cable_reset_type |=> plug_quiet)
      else $error("plug spoke after cable reset");
   a_hard_retry_gap: assert property (hard_sent |=> !(port_sym == pdrst_sym_hard_reset_type) [*8])
      else $error("hard reset repeated too soon");
   a_soft_single: assert property (port_sym == pdrst_sym_soft_reset_type |=>
      port_sym != pdrst_sym_soft_reset_type) else $error("soft reset longer than one symbol");
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
`define WAITC(c) begin int k; k = 0; while ((c) !== 1'b1 && k < 100) begin @(posedge clk_i); #1; k++; end \
   if (k >= 100) begin err_count++; test_done(); end end
module tb;
   import pdrst_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0;
   pdrst_phase_type phase_i = pdrst_ph_explicit_type;
   logic acting_source_i = 0, drp_source_default_i = 1, safe_zero_default_i = 1, protocol_error_i = 0;
   logic serious_error_i = 0, rx_soft_reset_i = 0, rx_hard_reset_i = 0, partner_response_i = 0, rx_sop_i = 0;
   logic sop_req_i = 0, sop_busy_i = 0, plug_req_i = 0, plug_dbl_i = 0, cable_reset_req_i = 0, mode_enter_i = 0;
   logic [7:0] plug_req_data_i = 8'h00, answer_data_i = 8'h00;
   logic answer_en_i = 1;
   logic tx_soft_reset_o, tx_hard_reset_o, supply_default_o, role_source_o, safe_zero_sel_o, safe_five_sel_o;
   logic modal_o, wait_for_source_offer_state_o, connection_ended_o, plug_busy_o, plug_done_o, sop_grant_o;
   logic self_reset_o;
   logic [7:0] plug_rx_data_o, last_req_o;
   logic [1:0] retry_count_o;
   int err_count = 0, total_checks = 0;
   pdrst_link_if lnk ();
   // short timeout keeps the retry walk to a few dozen cycles
   pdrst_port #(.NO_RESP_CYC(20)) pdrst_port_i (.clk_i, .rst_n_i, .phase_i, .acting_source_i,
      .drp_source_default_i, .safe_zero_default_i, .protocol_error_i, .serious_error_i, .rx_soft_reset_i,
      .rx_hard_reset_i, .partner_response_i, .rx_sop_i, .sop_req_i, .sop_busy_i, .plug_req_i, .plug_dbl_i,
      .plug_req_data_i, .cable_reset_req_i, .mode_enter_i, .link(lnk.port_end), .tx_soft_reset_o,
      .tx_hard_reset_o, .supply_default_o, .role_source_o, .safe_zero_sel_o, .safe_five_sel_o, .modal_o,
      .wait_for_source_offer_state_o, .connection_ended_o, .plug_busy_o, .plug_done_o, .plug_rx_data_o,
      .sop_grant_o, .retry_count_o);
   pdrst_plug pdrst_plug_i (.clk_i, .rst_n_i, .link(lnk.plug_end), .answer_data_i, .answer_en_i,
      .self_reset_o, .last_req_o);
   pdrst_monitor pdrst_monitor_i (.clk_i, .rst_n_i, .port_sym(lnk.port_sym), .port_data(lnk.port_data),
      .plug_sym(lnk.plug_sym), .plug_data(lnk.plug_data));

   always #5 clk_i = ~clk_i;

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // modal entry is cleared by hard reset but survives soft reset
   task automatic t_soft();
      @(posedge clk_i);
      mode_enter_i <= 1;
      @(posedge clk_i);
      mode_enter_i <= 0;
      protocol_error_i <= 1;
      @(posedge clk_i);
      protocol_error_i <= 0;
      #1;
      `CHK("soft", 1'b1, tx_soft_reset_o)
      `CHK("softsym", 1'b1, lnk.port_sym == pdrst_sym_soft_reset_type)
      `CHK("modal", 1'b1, modal_o)
   endtask

   // sink-acting dual-role port, source by default, safe zero selected when z is 1, safe five when z is 0
   task automatic hard_go(input logic z);
      @(posedge clk_i);
      serious_error_i <= 1;
      safe_zero_default_i <= z;
      @(posedge clk_i);
      serious_error_i <= 0;
      #1;
      `CHK("hard", 1'b1, tx_hard_reset_o)
      `CHK("wire", 1'b1, lnk.port_sym == pdrst_sym_hard_reset_type)
      `CHK("supply", 1'b1, supply_default_o)
      `CHK("role", 1'b1, role_source_o)
      `CHK("vsel", {z, ~z}, {safe_zero_sel_o, safe_five_sel_o})
      `CHK("modal", 1'b0, modal_o)
   endtask

   task automatic t_hard();
      hard_go(1'b1);
      @(posedge clk_i);
      #1;
      `CHK("plugrst", 1'b1, self_reset_o)
      `WAITC(tx_hard_reset_o)
      `CHK("retry", 2'h1, retry_count_o)
      @(posedge clk_i);
      partner_response_i <= 1;
      @(posedge clk_i);
      partner_response_i <= 0;
      #1;
      `CHK("clear", 2'h0, retry_count_o)
   endtask

   task automatic t_plug(input logic dbl, input logic [7:0] d);
      @(posedge clk_i);
      plug_req_i <= 1;
      plug_dbl_i <= dbl;
      plug_req_data_i <= d;
      answer_data_i <= ~d;
      @(posedge clk_i);
      plug_req_i <= 0;
      #1;
      `WAITC(plug_done_o)
      `CHK("rx", ~d, plug_rx_data_o)
      `CHK("req", d, last_req_o)
   endtask

   // an acting source may reach the plug before connection and during contract setup
   task automatic t_src_plug(input pdrst_phase_type ph);
      @(posedge clk_i);
      phase_i <= ph;
      acting_source_i <= 1;
      t_plug(1'b0, 8'h3c);
      @(posedge clk_i);
      phase_i <= pdrst_ph_explicit_type;
      acting_source_i <= 0;
   endtask

   // refused: forming connection even for a source, setup without source, double prime before connection
   task automatic t_refuse(input pdrst_phase_type ph, input logic src, input logic dbl);
      @(posedge clk_i);
      phase_i <= ph;
      acting_source_i <= src;
      plug_dbl_i <= dbl;
      plug_req_i <= 1;
      @(posedge clk_i);
      plug_req_i <= 0;
      phase_i <= pdrst_ph_explicit_type;
      acting_source_i <= 0;
      #1;
      `CHK("busy", 1'b0, plug_busy_o)
      `CHK("quiet", 1'b1, lnk.port_sym == pdrst_sym_idle_type)
   endtask

   // silent plug: exchange must wait, then be cut by sop traffic
   task automatic t_abort();
      @(posedge clk_i);
      answer_en_i <= 0;
      plug_req_i <= 1;
      @(posedge clk_i);
      plug_req_i <= 0;
      repeat (30) @(posedge clk_i);
      rx_sop_i <= 1;
      #1;
      `CHK("wait", 1'b1, plug_busy_o)
      @(posedge clk_i);
      rx_sop_i <= 0;
      plug_req_i <= 1;
      #1;
      `CHK("cut", 1'b0, plug_busy_o)
      @(posedge clk_i);
      plug_req_i <= 0;
      sop_req_i <= 1;
      @(posedge clk_i);
      sop_req_i <= 0;
      answer_en_i <= 1;
      #1;
      `CHK("pre", 2'b01, {plug_busy_o, sop_grant_o})
   endtask

   task automatic t_cable();
      @(posedge clk_i);
      cable_reset_req_i <= 1;
      @(posedge clk_i);
      cable_reset_req_i <= 0;
      #1;
      `WAITC(self_reset_o)
      `CHK("cable", 1'b1, self_reset_o)
   endtask

   // received hard reset restores defaults without echo; received soft reset stops the retry timer
   task automatic t_rx();
      @(posedge clk_i);
      mode_enter_i <= 1;
      @(posedge clk_i);
      mode_enter_i <= 0;
      rx_hard_reset_i <= 1;
      @(posedge clk_i);
      rx_hard_reset_i <= 0;
      #1;
      `CHK("rxmodal", 1'b0, modal_o)
      `CHK("rxsup", 1'b1, supply_default_o)
      `CHK("rxecho", 1'b0, tx_hard_reset_o)
      hard_go(1'b1);
      @(posedge clk_i);
      rx_soft_reset_i <= 1;
      @(posedge clk_i);
      rx_soft_reset_i <= 0;
      repeat (30)
      begin
         @(posedge clk_i);
         #1;
         `CHK("nohard", 1'b0, tx_hard_reset_o)
      end
      `CHK("keep", 1'b1, supply_default_o)
      `CHK("rxretry", 2'h0, retry_count_o)
   endtask

   task automatic t_retry();
      hard_go(1'b0);
      for (int i = 1; i <= 2; i++)
      begin
         @(posedge clk_i);
         #1;
         `WAITC(tx_hard_reset_o)
         `CHK("retry", i[1:0], retry_count_o)
      end
      `WAITC(wait_for_source_offer_state_o)
      `CHK("ended", 1'b1, connection_ended_o)
      `CHK("nomore", 1'b0, tx_hard_reset_o)
   endtask

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1;
      t_soft();
      t_hard();
      t_plug(1'b0, 8'h5a);
      t_plug(1'b1, 8'ha5);
      t_src_plug(pdrst_ph_none_type);
      t_src_plug(pdrst_ph_contract_setup_type);
      t_refuse(pdrst_ph_establishing_type, 1'b1, 1'b0);
      t_refuse(pdrst_ph_contract_setup_type, 1'b0, 1'b0);
      t_refuse(pdrst_ph_none_type, 1'b1, 1'b1);
      t_abort();
      t_cable();
      t_rx();
      t_retry();
      test_done();
   end
endmodule
`default_nettype wire
